// file: hdl/sdrcb_defs.svh
/*
 * Constants of the SDRAM command, bank and read burst logic: pin field
 * positions, mode field layout, reset values and burst codes.
 * Assumes it is included by bare name wherever these macros are needed.
 */
`ifndef SDRCB_DEFS_SVH
`define SDRCB_DEFS_SVH

// ----------------------------------------------------------------------
// address pin fields
// ----------------------------------------------------------------------
`define SDRCB_AP_BIT 10
`define SDRCB_COL_MSB 7
`define SDRCB_ROW_W 12
`define SDRCB_COL_W 8
`define SDRCB_BANKS 4
`define SDRCB_LANES 4

// ----------------------------------------------------------------------
// mode field layout and reset values
// ----------------------------------------------------------------------
`define SDRCB_MR_BL_LSB 0
`define SDRCB_MR_BL_MSB 2
`define SDRCB_MR_CL_LSB 4
`define SDRCB_MR_CL_MSB 6
`define SDRCB_BL_RESET 3'h0
`define SDRCB_CL_RESET 3'h2
`define SDRCB_CL_THREE 3'h3

// ----------------------------------------------------------------------
// burst codes and lengths
// ----------------------------------------------------------------------
`define SDRCB_BL_1 3'h0
`define SDRCB_BL_2 3'h1
`define SDRCB_BL_4 3'h2
`define SDRCB_BL_8 3'h3
`define SDRCB_BL_FULL 3'h7
`define SDRCB_LAST_COL 8'hFF

`endif

// file: hdl/sdrcb_pkg.sv
/*
 * Types of the SDRAM command, bank and read burst logic.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sdrcb_pkg;

    typedef enum logic [3:0] {
        SDRCB_CMD_NONE,
        SDRCB_CMD_DESELECT,
        SDRCB_CMD_NOP,
        SDRCB_CMD_ROW_OPEN,
        SDRCB_CMD_CLOSE,
        SDRCB_CMD_READ,
        SDRCB_CMD_WRITE,
        SDRCB_CMD_BURST_STOP,
        SDRCB_CMD_MODE_SET,
        SDRCB_CMD_AUTO_REFRESH,
        SDRCB_CMD_SELF_REFRESH
    } sdrcb_cmd_t;

    typedef enum logic [1:0] {
        SDRCB_PWR_RUN,
        SDRCB_PWR_SUSPEND,
        SDRCB_PWR_DOWN,
        SDRCB_PWR_SELF_REFRESH
    } sdrcb_pwr_t;

endpackage

// file: hdl/sdrcb_decode.sv
/*
 * Command decoder: turns the sampled command pins into one command.
 * Assumes all inputs are sampled on the same clock as the caller's logic.
 */
`timescale 1ns/100ps
module sdrcb_decode (
    input wire logic cke_prev,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    output sdrcb_pkg::sdrcb_cmd_t cmd
);
    import sdrcb_pkg::*;

    always_comb begin
        cmd = SDRCB_CMD_NONE;
        if (!cke_prev) begin
            cmd = SDRCB_CMD_NONE;
        end else if (cs_n) begin
            cmd = SDRCB_CMD_DESELECT;
        end else begin
            case ({ras_n, cas_n, we_n})
                3'h7: cmd = SDRCB_CMD_NOP;
                3'h3: cmd = SDRCB_CMD_ROW_OPEN;
                3'h2: cmd = SDRCB_CMD_CLOSE;
                3'h5: cmd = SDRCB_CMD_READ;
                3'h4: cmd = SDRCB_CMD_WRITE;
                3'h6: cmd = SDRCB_CMD_BURST_STOP;
                3'h0: cmd = SDRCB_CMD_MODE_SET;
                3'h1: cmd = cke ? SDRCB_CMD_AUTO_REFRESH : SDRCB_CMD_SELF_REFRESH;
                default: cmd = SDRCB_CMD_NOP;
            endcase
        end
    end

endmodule

// file: hdl/sdrcb_read_pipe.sv
/*
 * Read output stage: CAS latency delay and byte mask gating of the data pins.
 * Assumes the array word for the issued column is valid in the same cycle.
 */
`timescale 1ns/100ps
`include "sdrcb_defs.svh"
module sdrcb_read_pipe (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic cl3,
    input wire logic issue_valid,
    input wire logic [31:0] issue_data,
    input wire logic [3:0] dqm,
    output logic [31:0] dq_out,
    output logic [3:0] dq_oe_n
);
    import sdrcb_pkg::*;

    logic stage_valid_reg;
    logic [31:0] stage_data_reg;
    logic [3:0] dqm_reg;
    logic src_valid;
    logic [31:0] src_data;

    // ----------------------------------------------------------------------
    // latency selection
    // ----------------------------------------------------------------------
    assign src_valid = cl3 ? stage_valid_reg : issue_valid;
    assign src_data = cl3 ? stage_data_reg : issue_data;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage_valid_reg <= 1'b0;
            stage_data_reg <= 32'h0;
        end else if (run) begin
            stage_valid_reg <= issue_valid;
            stage_data_reg <= issue_data;
        end
    end

    // ----------------------------------------------------------------------
    // byte mask, two clocks ahead of the data it gates
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dqm_reg <= 4'hF;
        end else if (run) begin
            dqm_reg <= dqm;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dq_out <= 32'h0;
            dq_oe_n <= 4'hF;
        end else if (run) begin
            dq_out <= src_data;
            for (int i = 0; i < `SDRCB_LANES; i++) begin
                dq_oe_n[i] <= ~(src_valid & ~dqm_reg[i]);
            end
        end
    end

    AST_DQM_LATENCY: assert property (@(posedge clock) disable iff (!rst_n)
        (run && dqm[0]) ##1 run |=> dq_oe_n[0])
        else $error("masked lane drove data two clocks after mask");

    AST_IDLE_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
        (run && !issue_valid && !stage_valid_reg) |=> (dq_oe_n == 4'hF))
        else $error("data pins driven with no burst word");

endmodule

// file: hdl/sdrcb_top.sv
/*
 * SDRAM command decoding, bank state and read/write burst sequencing.
 * Assumes a controller on the same clock drives the pins, and an array
 * that returns the addressed word combinationally.
 */
`timescale 1ns/100ps
`include "sdrcb_defs.svh"
module sdrcb_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [11:0] addr,
    input wire logic [3:0] dqm,
    input wire logic [31:0] dq_in,
    output logic [31:0] dq_out,
    output logic [3:0] dq_oe_n,
    output logic [1:0] array_bank,
    output logic [11:0] array_row,
    output logic [7:0] array_col,
    input wire logic [31:0] array_rdata,
    output logic array_we,
    output logic [31:0] array_wdata,
    output logic [3:0] array_be,
    output sdrcb_pkg::sdrcb_pwr_t power_state
);
    import sdrcb_pkg::*;

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    function automatic logic [8:0] burst_len(input logic [2:0] bl);
        case (bl)
            `SDRCB_BL_1: burst_len = 9'h001;
            `SDRCB_BL_2: burst_len = 9'h002;
            `SDRCB_BL_4: burst_len = 9'h004;
            `SDRCB_BL_8: burst_len = 9'h008;
            default: burst_len = 9'h100;
        endcase
    endfunction

    function automatic logic [7:0] next_col(input logic [7:0] col, input logic [2:0] bl);
        logic [7:0] inc;
        logic [7:0] wrap;
        inc = col + 8'h01;
        case (bl)
            `SDRCB_BL_2: wrap = 8'h01;
            `SDRCB_BL_4: wrap = 8'h03;
            `SDRCB_BL_8: wrap = 8'h07;
            default: wrap = 8'hFF;
        endcase
        next_col = (col & ~wrap) | (inc & wrap);
    endfunction

    logic cke_reg;
    logic run;
    sdrcb_cmd_t cmd;
    logic [2:0] cl_reg;
    logic [2:0] bl_reg;
    logic [3:0] bank_open_reg;
    logic [11:0] bank_row_reg [0:3];
    logic burst_act_reg;
    logic burst_wr_reg;
    logic burst_ap_reg;
    logic [8:0] remain_reg;
    logic burst_last;
    logic ap_close;
    logic addr_ap;
    logic col_cmd;

    // ----------------------------------------------------------------------
    // clock enable and command decode
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cke_reg <= 1'b1;
        end else begin
            cke_reg <= cke;
        end
    end

    assign run = cke_reg;
    assign addr_ap = addr[`SDRCB_AP_BIT];

    sdrcb_decode u_decode (
        .cke_prev(cke_reg),
        .cke(cke),
        .cs_n(cs_n),
        .ras_n(ras_n),
        .cas_n(cas_n),
        .we_n(we_n),
        .cmd(cmd)
    );

    assign col_cmd = (cmd == SDRCB_CMD_READ || cmd == SDRCB_CMD_WRITE) && bank_open_reg[ba];
    assign burst_last = burst_act_reg && (bl_reg != `SDRCB_BL_FULL) && (remain_reg == 9'h001);
    assign ap_close = burst_last && burst_ap_reg && run;

    // ----------------------------------------------------------------------
    // power modes
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            power_state <= SDRCB_PWR_RUN;
        end else if (cke_reg && !cke) begin
            if (burst_act_reg) begin
                power_state <= SDRCB_PWR_SUSPEND;
            end else if (cmd == SDRCB_CMD_SELF_REFRESH && bank_open_reg == 4'h0) begin
                power_state <= SDRCB_PWR_SELF_REFRESH;
            end else begin
                power_state <= SDRCB_PWR_DOWN;
            end
        end else if (!cke_reg && cke) begin
            power_state <= SDRCB_PWR_RUN;
        end
    end

    // ----------------------------------------------------------------------
    // mode settings
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cl_reg <= `SDRCB_CL_RESET;
            bl_reg <= `SDRCB_BL_RESET;
        end else if (cmd == SDRCB_CMD_MODE_SET && bank_open_reg == 4'h0) begin
            cl_reg <= addr[`SDRCB_MR_CL_MSB:`SDRCB_MR_CL_LSB];
            bl_reg <= addr[`SDRCB_MR_BL_MSB:`SDRCB_MR_BL_LSB];
        end
    end

    // ----------------------------------------------------------------------
    // bank state
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bank_open_reg <= 4'h0;
            for (int i = 0; i < `SDRCB_BANKS; i++) begin
                bank_row_reg[i] <= 12'h000;
            end
        end else begin
            if (ap_close) begin
                bank_open_reg[array_bank] <= 1'b0;
            end
            case (cmd)
                SDRCB_CMD_ROW_OPEN: begin
                    if (!bank_open_reg[ba]) begin
                        bank_open_reg[ba] <= 1'b1;
                        bank_row_reg[ba] <= addr;
                    end
                end
                SDRCB_CMD_CLOSE: begin
                    if (addr_ap) begin
                        bank_open_reg <= 4'h0;
                    end else begin
                        bank_open_reg[ba] <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // burst sequencing
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            burst_act_reg <= 1'b0;
            burst_wr_reg <= 1'b0;
            burst_ap_reg <= 1'b0;
            remain_reg <= 9'h000;
            array_bank <= 2'h0;
            array_row <= 12'h000;
            array_col <= 8'h00;
        end else if (run) begin
            if (burst_act_reg) begin
                array_col <= next_col(array_col, bl_reg);
                if (bl_reg != `SDRCB_BL_FULL) begin
                    remain_reg <= remain_reg - 9'h001;
                end
                if (burst_last) begin
                    burst_act_reg <= 1'b0;
                end
            end
            if (col_cmd) begin
                burst_act_reg <= 1'b1;
                burst_wr_reg <= (cmd == SDRCB_CMD_WRITE);
                burst_ap_reg <= addr_ap && (bl_reg != `SDRCB_BL_FULL);
                remain_reg <= burst_len(bl_reg);
                array_bank <= ba;
                array_row <= bank_row_reg[ba];
                array_col <= addr[`SDRCB_COL_MSB:0];
            end else if (cmd == SDRCB_CMD_BURST_STOP && burst_act_reg && !burst_ap_reg) begin
                burst_act_reg <= 1'b0;
            end else if (cmd == SDRCB_CMD_CLOSE && burst_act_reg && (addr_ap || ba == array_bank)) begin
                burst_act_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // write path into the array
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            array_we <= 1'b0;
            array_wdata <= 32'h0;
            array_be <= 4'h0;
        end else begin
            array_we <= run && ((col_cmd && cmd == SDRCB_CMD_WRITE) ||
                (burst_act_reg && burst_wr_reg && !burst_last && !col_cmd && cmd != SDRCB_CMD_BURST_STOP));
            array_wdata <= dq_in;
            array_be <= ~dqm;
        end
    end

    // ----------------------------------------------------------------------
    // read output stage
    // ----------------------------------------------------------------------
    sdrcb_read_pipe u_read_pipe (
        .clock(clock),
        .rst_n(rst_n),
        .run(run),
        .cl3(cl_reg == `SDRCB_CL_THREE),
        .issue_valid(burst_act_reg && !burst_wr_reg),
        .issue_data(array_rdata),
        .dqm(dqm),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n)
    );

    // ----------------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------------
    AST_ROW_OPEN: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd == SDRCB_CMD_ROW_OPEN && !bank_open_reg[ba])
        |=> bank_open_reg[$past(ba)] && bank_row_reg[$past(ba)] == $past(addr))
        else $error("row open did not open the bank");

    AST_CLOSE_ONE: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd == SDRCB_CMD_CLOSE && !addr_ap) |=> !bank_open_reg[$past(ba)])
        else $error("single bank close left bank open");

    AST_CLOSE_ALL: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd == SDRCB_CMD_CLOSE && addr_ap) |=> bank_open_reg == 4'h0)
        else $error("all bank close left a bank open");

    AST_DESELECT_IGNORED: assert property (@(posedge clock) disable iff (!rst_n)
        (cke_reg && cs_n && !burst_act_reg) |=> $stable(bank_open_reg) && $stable(cl_reg))
        else $error("deselected command changed state");

    AST_READ_START: assert property (@(posedge clock) disable iff (!rst_n)
        (cmd == SDRCB_CMD_READ && bank_open_reg[ba])
        |=> burst_act_reg && !burst_wr_reg && array_col == $past(addr[7:0]))
        else $error("read did not start at the given column");

    AST_FULL_PAGE_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
        (run && burst_act_reg && bl_reg == `SDRCB_BL_FULL && array_col == `SDRCB_LAST_COL
        && cmd == SDRCB_CMD_NOP) |=> burst_act_reg && array_col == 8'h00)
        else $error("full page burst did not wrap to column zero");

    AST_SUSPEND_FREEZE: assert property (@(posedge clock) disable iff (!rst_n)
        !cke_reg |=> $stable(array_col) && $stable(remain_reg) && $stable(dq_oe_n))
        else $error("state moved while clock suspended");

    AST_SUSPEND_IN_BURST: assert property (@(posedge clock) disable iff (!rst_n)
        (cke_reg && !cke && burst_act_reg) |=> power_state == SDRCB_PWR_SUSPEND)
        else $error("power down entered inside a burst");

    AST_AUTO_CLOSE: assert property (@(posedge clock) disable iff (!rst_n)
        (ap_close && cmd == SDRCB_CMD_NOP) |=> !bank_open_reg[$past(array_bank)])
        else $error("auto precharge did not close the bank");

endmodule

// file: bench/sdrcb_ctl_model.sv
/*
 * Memory controller model: drives command, address, mask, clock enable
 * and write data pins, holding off commands until its timing limits allow.
 * Assumes callers stand just after a falling clock edge.
 */
`timescale 1ns/100ps
module sdrcb_ctl_model #(
    parameter int T_RCD = 2,
    parameter int T_RC = 7,
    parameter int T_RRD = 2,
    parameter int T_RAS = 5
) (
    input wire logic clock,
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [1:0] ba,
    output logic [11:0] addr,
    output logic [3:0] dqm,
    output logic [31:0] dq_in
);
    logic [3:0] mask = 4'h0;
    logic cke_v = 1'b1;
    int cyc = 0;
    int act_at [4] = '{-100, -100, -100, -100};
    int last_act = -100;
    assign dqm = mask;
    assign cke = cke_v;
    initial begin
        {cs_n, ras_n, cas_n, we_n} = 4'h7;
        ba = 2'h0;
        addr = 12'h000;
        dq_in = 32'h0;
    end
    always @(posedge clock) cyc <= cyc + 1;
    // ------------------------------------------------------------------
    // one command, driven at a falling edge, taken at the next rising one
    // ------------------------------------------------------------------
    task automatic op(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a, input logic [31:0] d);
        int ready_at;
        ready_at = cyc;
        if (c == 4'h3) begin
            ready_at = last_act + T_RRD;
            if (act_at[b] + T_RC > ready_at) ready_at = act_at[b] + T_RC;
        end else if (c[3:1] == 3'h2) begin
            ready_at = act_at[b] + T_RCD;
        end else if (c == 4'h2) begin
            for (int i = 0; i < 4; i++)
                if ((a[10] || i == b) && act_at[i] + T_RAS > ready_at) ready_at = act_at[i] + T_RAS;
        end
        while (cyc < ready_at) @(negedge clock);
        {cs_n, ras_n, cas_n, we_n} <= c;
        ba <= b;
        addr <= a;
        dq_in <= d;
        if (c == 4'h3) begin
            act_at[b] = cyc;
            last_act = cyc;
        end
        // released just after the taking edge, so back-to-back commands never glitch
        @(posedge clock);
        {cs_n, ras_n, cas_n, we_n} <= 4'h7;
        ba <= ~b;
        addr <= ~a;
        dq_in <= ~d;
        @(negedge clock);
    endtask
endmodule

// file: bench/tb_sdram_cmd_bank_read_logic.sv
/*
 * Self-checking bench of the command, bank and read burst logic.
 * Assumes the controller model beside it; a bank is never left open long.
 */
`timescale 1ns/100ps
module tb_sdram_cmd_bank_read_logic;
    import sdrcb_pkg::*;
    localparam logic [3:0] c_act = 4'h3, c_pre = 4'h2, c_rd = 4'h5, c_wr = 4'h4;
    localparam logic [3:0] c_stop = 4'h6, c_mrs = 4'h0, c_ref = 4'h1, c_nop = 4'h7;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cke, cs_n, ras_n, cas_n, we_n, array_we;
    logic [1:0] ba, array_bank;
    logic [11:0] addr, array_row;
    logic [7:0] array_col;
    logic [3:0] dqm, dq_oe_n, array_be;
    logic [31:0] dq_in, dq_out, array_rdata, array_wdata;
    sdrcb_pwr_t power_state;
    int mismatches = 0;
    int num_checks = 0;
    always #10 clock = ~clock;
    assign array_rdata = {4'hA, array_bank, array_row, array_col, 6'h15};
    sdrcb_top sdrcb_top_i (.clock(clock), .rst_n(rst_n), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .array_bank(array_bank), .array_row(array_row), .array_col(array_col), .array_rdata(array_rdata),
        .array_we(array_we), .array_wdata(array_wdata), .array_be(array_be), .power_state(power_state));
    sdrcb_ctl_model sdrcb_ctl_model_i (.clock(clock), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
        .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] word(input logic [1:0] b, input logic [11:0] r, input logic [7:0] c);
        return {4'hA, b, r, c, 6'h15};
    endfunction
    function automatic logic [31:0] lanes(input logic [3:0] m);
        return {{8{~m[3]}}, {8{~m[2]}}, {8{~m[1]}}, {8{~m[0]}}};
    endfunction
    function automatic logic [3:0] pat(input int i);
        return (i == 1) ? 4'h5 : (i == 2) ? 4'h8 : 4'h0;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t %s: saw %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
        sdrcb_ctl_model_i.op(c, b, a, 32'h0);
    endtask
    task automatic quiet(input string what);
        repeat (4) begin
            @(negedge clock);
            check({28'h0, dq_oe_n}, 32'hF, what);
        end
    endtask
    task automatic pwr(input sdrcb_pwr_t p);
        check({30'h0, power_state}, {30'h0, p}, "power state");
    endtask
    task automatic mode(input logic [11:0] a);
        cmd(c_mrs, 2'h0, a);
        repeat (2) @(negedge clock);
    endtask
    task automatic burst(input logic [1:0] b, input logic [11:0] r, input logic [7:0] col, input int cl,
                         input int n, input int blen, input bit stop);
        int i;
        logic [7:0] c;
        logic [3:0] m;
        sdrcb_ctl_model_i.mask = pat(2 - cl);
        cmd(c_rd, b, {4'h0, col});
        for (int k = 1; k <= n + cl; k++) begin
            sdrcb_ctl_model_i.mask = pat(k - cl + 2);
            if (stop && k == n) cmd(c_stop, 2'h0, 12'h000);
            else @(negedge clock);
            i = k - cl + 1;
            c = (col & ~8'(blen - 1)) | 8'((col + i) & (blen - 1));
            m = (i >= 0 && i < n) ? pat(i) : 4'hF;
            check({28'h0, dq_oe_n}, {28'h0, m}, "lane enables");
            if (m != 4'hF) check(dq_out & lanes(m), word(b, r, c) & lanes(m), "read word");
        end
        sdrcb_ctl_model_i.mask = 4'h0;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_read();
        check({28'h0, dq_oe_n}, 32'hF, "idle lanes");
        pwr(SDRCB_PWR_RUN);
        mode(12'h022);
        cmd(c_act, 2'h1, 12'h123);
        burst(2'h1, 12'h123, 8'h06, 2, 4, 4, 1'b0);
        cmd(c_pre, 2'h0, 12'h400);
        mode(12'h037);
        cmd(c_act, 2'h2, 12'hABC);
        burst(2'h2, 12'hABC, 8'hFE, 3, 4, 256, 1'b1);
        cmd(c_pre, 2'h2, 12'h000);
        mode(12'h023);
        cmd(c_act, 2'h0, 12'h001);
        burst(2'h0, 12'h001, 8'h0D, 2, 8, 8, 1'b0);
        cmd(c_pre, 2'h0, 12'h400);
        mode(12'h021);
        cmd(c_act, 2'h3, 12'h456);
        burst(2'h3, 12'h456, 8'h03, 2, 2, 2, 1'b0);
        cmd(c_pre, 2'h3, 12'h000);
        $display("test read bursts done");
    endtask
    task automatic t_interrupt();
        mode(12'h022);
        cmd(c_act, 2'h0, 12'h055);
        cmd(c_act, 2'h3, 12'h0AA);
        cmd(c_rd, 2'h0, 12'h010);
        cmd(c_rd, 2'h3, 12'h024);
        check(dq_out, word(2'h0, 12'h055, 8'h10), "first word");
        @(negedge clock);
        check(dq_out, word(2'h3, 12'h0AA, 8'h24), "second read");
        repeat (5) @(negedge clock);
        cmd(c_rd, 2'h3, 12'h030);
        sdrcb_ctl_model_i.mask = 4'hF;
        @(negedge clock);
        check(dq_out, word(2'h3, 12'h0AA, 8'h30), "word before write");
        @(negedge clock);
        check({28'h0, dq_oe_n}, 32'hF, "gap before write");
        sdrcb_ctl_model_i.mask = 4'h0;
        sdrcb_ctl_model_i.op(c_wr, 2'h3, 12'h031, 32'h1234_5678);
        check({31'h0, array_we}, 32'h1, "write strobe");
        check(array_wdata, 32'h1234_5678, "write data");
        check({28'h0, array_be}, 32'hF, "unmasked write");
        check({24'h0, array_col}, 32'h31, "write column");
        @(negedge clock);
        check({28'h0, dq_oe_n}, 32'hF, "read stopped by write");
        repeat (4) @(negedge clock);
        cmd(c_pre, 2'h0, 12'h400);
        $display("test interrupts done");
    endtask
    task automatic t_close();
        cmd(c_act, 2'h1, 12'h010);
        cmd(c_act, 2'h2, 12'h020);
        cmd(c_pre, 2'h1, 12'h000);
        cmd(c_rd, 2'h1, 12'h000);
        quiet("closed bank");
        burst(2'h2, 12'h020, 8'h00, 2, 4, 4, 1'b0);
        cmd(4'hD, 2'h2, 12'h000);
        quiet("deselected");
        cmd(c_rd, 2'h2, 12'h404);
        repeat (6) @(negedge clock);
        cmd(c_rd, 2'h2, 12'h000);
        quiet("auto closed");
        cmd(c_act, 2'h2, 12'h020);
        cmd(c_pre, 2'h1, 12'h400);
        cmd(c_rd, 2'h2, 12'h000);
        quiet("all closed");
        $display("test bank close done");
    endtask
    task automatic t_power();
        logic [31:0] hold;
        cmd(c_act, 2'h0, 12'h077);
        cmd(c_rd, 2'h0, 12'h000);
        sdrcb_ctl_model_i.cke_v = 1'b0;
        @(negedge clock);
        hold = dq_out;
        @(negedge clock);
        pwr(SDRCB_PWR_SUSPEND);
        check(dq_out, hold, "frozen output");
        sdrcb_ctl_model_i.cke_v = 1'b1;
        repeat (3) @(negedge clock);
        pwr(SDRCB_PWR_RUN);
        repeat (5) @(negedge clock);
        cmd(c_pre, 2'h0, 12'h400);
        sdrcb_ctl_model_i.cke_v = 1'b0;
        cmd(c_nop, 2'h0, 12'h000);
        @(negedge clock);
        pwr(SDRCB_PWR_DOWN);
        sdrcb_ctl_model_i.cke_v = 1'b1;
        repeat (3) @(negedge clock);
        pwr(SDRCB_PWR_RUN);
        cmd(c_ref, 2'h0, 12'h000);
        pwr(SDRCB_PWR_RUN);
        sdrcb_ctl_model_i.cke_v = 1'b0;
        cmd(c_ref, 2'h0, 12'h000);
        @(negedge clock);
        pwr(SDRCB_PWR_SELF_REFRESH);
        sdrcb_ctl_model_i.cke_v = 1'b1;
        repeat (3) @(negedge clock);
        pwr(SDRCB_PWR_RUN);
        $display("test power modes done");
    endtask
    // ------------------------------------------------------------------
    // run control
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clock);
        mismatches++;
        $display("BAD %0t run did not finish", $time);
        summarize();
    end
    initial begin
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        t_read();
        t_interrupt();
        t_close();
        t_power();
        summarize();
    end
endmodule
